// >>> include/cpr_defs.svh
// constants of the chained pen and ring control block: offsets, field positions, reset values
// assumes inclusion by bare name from the package and the design file
`ifndef CPR_DEFS_SVH
`define CPR_DEFS_SVH

// register offsets on the processor port
`define CPR_ADDR_W 4
`define CPR_OFS_CTRL 4'h0
`define CPR_OFS_STATUS 4'h4
`define CPR_OFS_ACK 4'h8

// control register fields
`define CPR_CTL_FOLLOWER 0
`define CPR_CTL_HIT_CLEAR 1
`define CPR_CTL_ANSWER 2
`define CPR_CTL_READY 3
`define CPR_CTL_TRIG_DRIVE 4
`define CPR_CTL_W 5
`define CPR_CTL_RESET 5'h00

// status register fields
`define CPR_ST_HIT_N 0
`define CPR_ST_BTN_IRQ 1
`define CPR_ST_ALL_READY 2
`define CPR_ST_TRIG_SRC_N 3
`define CPR_ST_RING_UP 4
`define CPR_ST_FOL_RESET 5

// acknowledge register fields, write one to clear
`define CPR_ACK_BTN 0
`define CPR_ACK_FOL_RESET 5

`endif

// >>> include/cpr_pkg.sv
// types of the chained pen and ring control block
// assumes cpr_defs.svh sits in the include path
`include "cpr_defs.svh"

package cpr_pkg;

  // software controls
  typedef struct packed {
    logic trig_drive;
    logic ready;
    logic answer;
    logic hit_clear;
    logic follower;
  } cpr_ctrl_t;

  // open-collector line seen from the pin side
  typedef struct packed {
    logic o;
    logic oe;
  } cpr_oc_t;

  // whole state of the block
  typedef struct packed {
    cpr_ctrl_t ctrl;
    logic hit;
    logic btn_irq;
    logic ring_up;
    logic fol_reset_flag;
    logic pulse_prev;
    logic btn_prev;
    logic hit_n_b;
    logic clr_b;
    logic trig_n_b;
    logic ext_trig_n_b;
    logic all_ready_b;
    logic trig_src_prev;
    logic trig_pulse;
    logic fol_reset_pulse;
    logic [31:0] rdata;
  } cpr_state_t;

endpackage : cpr_pkg

// >>> rtl/cpr_ctrl.sv
// pen latch, button interrupt, ring retransmit, trigger selection and bused ready lines
// assumes inputs synchronous to clk; the bench resolves open-collector wires from o and oe
//
// Design decisions made here: the plain strobed port and the register offsets.
`include "cpr_defs.svh"

module cpr_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // processor register port
  input wire logic [`CPR_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // processor side levels and one-cycle pulses (trig_irq, follower_reset)
  output logic hit_port_input,
  output logic pen_irq_input,
  output logic trig_irq,
  output logic follower_reset,
  output logic tx_gate,
  // light pen
  input wire logic light_detect_pulse,
  input wire logic pen_button_n,
  // serial ring
  input wire logic local_tx,
  output logic local_rx,
  input wire logic ring_rx,
  output logic ring_tx,
  // external trigger connector
  input wire logic ext_trig_n,
  // bused chain lines, open collector
  input wire logic pen_hit_n_in,
  output logic pen_hit_n_out,
  output logic pen_hit_n_oe,
  input wire logic pen_hit_clear_in,
  output logic pen_hit_clear_out,
  output logic pen_hit_clear_oe,
  input wire logic ring_trig_n_in,
  output logic ring_trig_n_out,
  output logic ring_trig_n_oe,
  input wire logic all_units_ready,
  output logic unit_ready_n_out,
  output logic unit_ready_n_oe
);

  cpr_pkg::cpr_state_t s_r;
  cpr_pkg::cpr_state_t s_nxt;
  logic light_rise;
  logic btn_fall;
  logic clr_any;
  logic trig_src_n;
  logic trig_fall;
  logic ack_btn;
  logic ack_fol;

  // edge decode of the raw inputs against registered previous values, source decode from registered state
  always_comb begin
    light_rise = light_detect_pulse & ~s_r.pulse_prev;
    btn_fall = s_r.btn_prev & ~pen_button_n;
    clr_any = s_r.ctrl.hit_clear | s_r.clr_b;
    trig_src_n = s_r.ctrl.follower ? s_r.trig_n_b : s_r.ext_trig_n_b;
    trig_fall = s_r.trig_src_prev & ~trig_src_n;
    ack_btn = wr && addr == `CPR_OFS_ACK && wdata[`CPR_ACK_BTN];
    ack_fol = wr && addr == `CPR_OFS_ACK && wdata[`CPR_ACK_FOL_RESET];
  end

  // processor hit input: own latch or the master's latch over the bus
  assign hit_port_input = s_r.ctrl.follower ? s_r.hit_n_b : ~s_r.hit;
  assign pen_irq_input = s_r.btn_irq;
  assign trig_irq = s_r.trig_pulse;
  assign follower_reset = s_r.fol_reset_pulse;
  assign rdata = s_r.rdata;

  // ring path; the gate is an AND in front of the OR so a follower stays transparent
  assign tx_gate = ~s_r.ctrl.follower | s_r.ctrl.answer;
  assign ring_tx = (local_tx & tx_gate) | ring_rx;
  assign local_rx = ring_rx;

  // open-collector drivers: out fixed low (the clear line fixed high), oe pulls the wire
  assign pen_hit_n_out = 1'b0;
  assign pen_hit_n_oe = ~s_r.ctrl.follower & s_r.hit;
  assign pen_hit_clear_out = 1'b1;
  assign pen_hit_clear_oe = s_r.ctrl.hit_clear;
  assign ring_trig_n_out = 1'b0;
  assign ring_trig_n_oe = ~s_r.ctrl.follower & s_r.ctrl.trig_drive;
  // ready not set means the line is pulled, as a unit that is not running must look
  assign unit_ready_n_out = 1'b0;
  assign unit_ready_n_oe = ~s_r.ctrl.ready;

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.pulse_prev = light_detect_pulse;
    s_nxt.btn_prev = pen_button_n;
    // receiver buffers in front of every bused input
    s_nxt.hit_n_b = pen_hit_n_in;
    s_nxt.clr_b = pen_hit_clear_in;
    s_nxt.trig_n_b = ring_trig_n_in;
    s_nxt.ext_trig_n_b = ext_trig_n;
    s_nxt.all_ready_b = all_units_ready;
    s_nxt.trig_src_prev = trig_src_n;
    // a fresh light edge beats a clear so a hit seen during the clear is kept
    if (light_rise) begin
      s_nxt.hit = 1'b1;
    end else if (clr_any) begin
      s_nxt.hit = 1'b0;
    end
    // sticky button flag, the edge wins over an acknowledge in the same cycle
    if (btn_fall) begin
      s_nxt.btn_irq = 1'b1;
    end else if (ack_btn) begin
      s_nxt.btn_irq = 1'b0;
    end
    // trigger from the selected source; a follower splits it by all-ready
    s_nxt.trig_pulse = trig_fall & (~s_r.ctrl.follower | s_r.all_ready_b);
    s_nxt.fol_reset_pulse = trig_fall & s_r.ctrl.follower & ~s_r.all_ready_b;
    if (s_nxt.fol_reset_pulse) begin
      s_nxt.fol_reset_flag = 1'b1;
    end else if (ack_fol) begin
      s_nxt.fol_reset_flag = 1'b0;
    end
    // register writes
    if (wr && addr == `CPR_OFS_CTRL) begin
      s_nxt.ctrl = wdata[`CPR_CTL_W-1:0];
    end
    // ring up follows the next ready bit so it drops in the same edge as our ready
    if (s_nxt.ctrl.ready && s_r.all_ready_b) begin
      s_nxt.ring_up = 1'b1;
    end else if (!s_nxt.ctrl.ready) begin
      s_nxt.ring_up = 1'b0;
    end
    // read data stands only in the cycle after the strobe
    s_nxt.rdata = 32'h0;
    if (rd) begin
      case (addr)
        `CPR_OFS_CTRL: s_nxt.rdata[`CPR_CTL_W-1:0] = s_r.ctrl;
        `CPR_OFS_STATUS: begin
          s_nxt.rdata[`CPR_ST_HIT_N] = hit_port_input;
          s_nxt.rdata[`CPR_ST_BTN_IRQ] = s_r.btn_irq;
          s_nxt.rdata[`CPR_ST_ALL_READY] = s_r.all_ready_b;
          s_nxt.rdata[`CPR_ST_TRIG_SRC_N] = trig_src_n;
          s_nxt.rdata[`CPR_ST_RING_UP] = s_r.ring_up;
          s_nxt.rdata[`CPR_ST_FOL_RESET] = s_r.fol_reset_flag;
        end
        default: s_nxt.rdata = 32'h0;
      endcase
    end
  end

  // state register; reset leaves ready negated and the latch empty
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrl <= `CPR_CTL_RESET;
      s_r.pulse_prev <= 1'b1;
      s_r.btn_prev <= 1'b1;
      s_r.hit_n_b <= 1'b1;
      s_r.trig_n_b <= 1'b1;
      s_r.ext_trig_n_b <= 1'b1;
      s_r.trig_src_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_hit_set: assert property (light_rise |=> s_r.hit)
    else $error("hit latch not set after light edge");
  chk_hit_clear: assert property (clr_any && !light_rise |=> !s_r.hit)
    else $error("hit latch not cleared");
  chk_hit_bus: assert property (s_r.ctrl.follower |-> !pen_hit_n_oe && hit_port_input == s_r.hit_n_b)
    else $error("follower hit path wrong");
  chk_btn_irq: assert property ($fell(pen_button_n) |=> pen_irq_input ##1 pen_irq_input)
    else $error("button edge lost");
  chk_btn_hold: assert property (pen_irq_input && !ack_btn |=> pen_irq_input)
    else $error("button flag dropped without ack");
  chk_tx_gate: assert property (s_r.ctrl.follower && !s_r.ctrl.answer && !ring_rx |-> !ring_tx)
    else $error("follower transmitter not blocked");
  chk_retransmit: assert property (ring_rx |-> ring_tx)
    else $error("ring data not retransmitted");
  chk_trig_drive: assert property (s_r.ctrl.follower |-> !ring_trig_n_oe)
    else $error("follower drives ring trigger");
  chk_ready_off: assert property (!s_r.ctrl.ready |-> unit_ready_n_oe && !s_r.ring_up)
    else $error("not ready but line released");
  chk_fol_reset: assert property (trig_fall && s_r.ctrl.follower && !s_r.all_ready_b
    |=> follower_reset && !trig_irq)
    else $error("follower reset not raised");
  chk_reset_hit: assert property ($fell(reset) |-> !s_r.hit && !pen_irq_input)
    else $error("stale state after reset");

endmodule : cpr_ctrl

// >>> verif/cpr_pen_ring.sv
// light pen and neighbouring ring units, behavioural
// assumes the bench resolves the bused open-collector lines from the pull outputs
module cpr_pen_ring (
  // clock
  input wire logic clk,
  // pen
  output logic light_detect_pulse,
  output logic pen_button_n,
  // ring data and neighbour pulls on bused lines
  output logic ring_rx,
  output logic nbr_ready_pull,
  output logic nbr_trig_pull,
  output logic nbr_hit_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels; a powered-down neighbour holds ready negated
  initial begin
    light_detect_pulse = 1'b1;
    pen_button_n = 1'b1;
    ring_rx = 1'b1;
    nbr_ready_pull = 1'b1;
    nbr_trig_pull = 1'b0;
    nbr_hit_pull = 1'b0;
  end
  // low pulse of 15 us, 600 cycles at 40 MHz
  task automatic flash();
    @(posedge clk) light_detect_pulse <= 1'b0;
    repeat (600) @(posedge clk);
    light_detect_pulse <= 1'b1;
  endtask : flash
  // button held low for n cycles, already debounced
  task automatic press(input int n);
    @(posedge clk) pen_button_n <= 1'b0;
    repeat (n) @(posedge clk);
    pen_button_n <= 1'b1;
  endtask : press
  // one ring bit from the previous unit
  task automatic ring_bit(input logic v);
    @(posedge clk) ring_rx <= v;
  endtask : ring_bit
  // neighbour pulls the ready line low while busy or off
  task automatic set_ready_pull(input logic v);
    @(posedge clk) nbr_ready_pull <= v;
  endtask : set_ready_pull
  // master of the chain reports a hit on the shared line
  task automatic set_hit_pull(input logic v);
    @(posedge clk) nbr_hit_pull <= v;
  endtask : set_hit_pull
  // ring trigger asserted for two cycles
  task automatic pulse_trig();
    @(posedge clk) nbr_trig_pull <= 1'b1;
    repeat (2) @(posedge clk);
    nbr_trig_pull <= 1'b0;
  endtask : pulse_trig
endmodule : cpr_pen_ring

// >>> verif/tb.sv
// self-checking bench for the pen latch, ring and bused control lines
// assumes pull-ups on active-low bused lines and a pull-down on the clear line
`include "cpr_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, local_tx = 1'b0, ext_trig_n = 1'b1;
  logic clr_pull = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic hit_port_input, pen_irq_input, trig_irq, follower_reset, tx_gate, local_rx, ring_tx;
  logic light, btn, ring_rx, nr, nt, nh, hit_w, clr_w, trig_w, rdy_w;
  logic hit_o, hit_oe, clr_o, clr_oe, trig_o, trig_oe, rdy_o, rdy_oe;
  int err_count = 0, checked = 0, trig_cnt = 0, rst_cnt = 0;
  // wired lines: a party pulls only while its enable is high
  assign hit_w = (hit_oe ? hit_o : 1'b1) & !nh;
  assign clr_w = (clr_oe ? clr_o : 1'b0) | clr_pull;
  assign trig_w = (trig_oe ? trig_o : 1'b1) & !nt;
  assign rdy_w = (rdy_oe ? rdy_o : 1'b1) & !nr;
  initial forever #12.5 clk = ~clk;
  cpr_pen_ring pen (.clk(clk), .light_detect_pulse(light), .pen_button_n(btn),
    .ring_rx(ring_rx), .nbr_ready_pull(nr), .nbr_trig_pull(nt), .nbr_hit_pull(nh));
  cpr_ctrl DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .hit_port_input(hit_port_input), .pen_irq_input(pen_irq_input),
    .trig_irq(trig_irq), .follower_reset(follower_reset), .tx_gate(tx_gate),
    .light_detect_pulse(light), .pen_button_n(btn), .local_tx(local_tx), .local_rx(local_rx),
    .ring_rx(ring_rx), .ring_tx(ring_tx), .ext_trig_n(ext_trig_n), .pen_hit_n_in(hit_w),
    .pen_hit_n_out(hit_o), .pen_hit_n_oe(hit_oe), .pen_hit_clear_in(clr_w),
    .pen_hit_clear_out(clr_o), .pen_hit_clear_oe(clr_oe), .ring_trig_n_in(trig_w),
    .ring_trig_n_out(trig_o), .ring_trig_n_oe(trig_oe), .all_units_ready(rdy_w),
    .unit_ready_n_out(rdy_o), .unit_ready_n_oe(rdy_oe));
  // one-cycle event pulses are counted so a late look cannot miss them
  always @(posedge clk) begin
    if (trig_irq === 1'b1) trig_cnt <= trig_cnt + 1;
    if (follower_reset === 1'b1) rst_cnt <= rst_cnt + 1;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic ring_case(input logic ltx, input logic rrx, input logic etx);
    @(posedge clk) local_tx <= ltx;
    pen.ring_bit(rrx);
    #1 cmp_bit(ring_tx, etx);
    cmp_bit(local_rx, rrx);
  endtask : ring_case
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  // hang guard, far beyond the sequence length
  initial begin
    #1000000 err_count++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    settle(1);
    cmp_bit(hit_port_input, 1'b1);
    cmp_bit(tx_gate, 1'b1);
    cmp_bit(rdy_w, 1'b0);
    rd_reg(`CPR_OFS_CTRL, d);
    cmp_word(d, 32'h0);
    rd_reg(4'hc, d);
    cmp_word(d, 32'h0);
    // master latches the pen and drives the shared hit line
    pen.flash();
    settle(2);
    cmp_bit(hit_port_input, 1'b0);
    cmp_bit(hit_w, 1'b0);
    rd_reg(`CPR_OFS_STATUS, d);
    cmp_bit(d[`CPR_ST_HIT_N], 1'b0);
    wr_reg(`CPR_OFS_CTRL, 32'h1 << `CPR_CTL_HIT_CLEAR);
    cmp_bit(clr_w, 1'b1);
    wr_reg(`CPR_OFS_CTRL, 32'h0);
    settle(3);
    cmp_bit(hit_port_input, 1'b1);
    // another unit clears this latch over the bus
    pen.flash();
    @(posedge clk) clr_pull <= 1'b1;
    #1 cmp_bit(hit_port_input, 1'b0);
    @(posedge clk) clr_pull <= 1'b0;
    settle(3);
    cmp_bit(hit_port_input, 1'b1);
    pen.press(3);
    settle(2);
    cmp_bit(pen_irq_input, 1'b1);
    wr_reg(`CPR_OFS_ACK, 32'h1 << `CPR_ACK_BTN);
    cmp_bit(pen_irq_input, 1'b0);
    ring_case(1'b1, 1'b0, 1'b1);
    ring_case(1'b0, 1'b1, 1'b1);
    ring_case(1'b0, 1'b0, 1'b0);
    // follower: gate shut, no trigger drive, hit taken from the bus
    wr_reg(`CPR_OFS_CTRL, 32'h11);
    cmp_bit(tx_gate, 1'b0);
    cmp_bit(trig_oe, 1'b0);
    ring_case(1'b1, 1'b0, 1'b0);
    ring_case(1'b0, 1'b1, 1'b1);
    wr_reg(`CPR_OFS_CTRL, 32'h15);
    ring_case(1'b1, 1'b0, 1'b1);
    pen.flash();
    settle(2);
    cmp_bit(hit_oe, 1'b0);
    cmp_bit(hit_port_input, 1'b1);
    pen.set_hit_pull(1'b1);
    settle(2);
    cmp_bit(hit_port_input, 1'b0);
    pen.set_hit_pull(1'b0);
    @(posedge clk) ext_trig_n <= 1'b0;
    settle(6);
    @(posedge clk) ext_trig_n <= 1'b1;
    pen.pulse_trig();
    settle(6);
    cmp_word(trig_cnt, 32'h0);
    cmp_word(rst_cnt, 32'h1);
    rd_reg(`CPR_OFS_STATUS, d);
    cmp_bit(d[`CPR_ST_FOL_RESET], 1'b1);
    wr_reg(`CPR_OFS_ACK, 32'h1 << `CPR_ACK_FOL_RESET);
    rd_reg(`CPR_OFS_STATUS, d);
    cmp_bit(d[`CPR_ST_FOL_RESET], 1'b0);
    wr_reg(`CPR_OFS_CTRL, 32'h0d);
    pen.set_ready_pull(1'b0);
    settle(3);
    cmp_bit(rdy_w, 1'b1);
    rd_reg(`CPR_OFS_STATUS, d);
    cmp_bit(d[`CPR_ST_ALL_READY], 1'b1);
    pen.pulse_trig();
    settle(6);
    cmp_word(trig_cnt, 32'h1);
    pen.set_ready_pull(1'b1);
    settle(1);
    cmp_bit(rdy_w, 1'b0);
    // master takes the external input and may drive the ring trigger
    wr_reg(`CPR_OFS_CTRL, 32'h18);
    cmp_bit(trig_oe, 1'b1);
    @(posedge clk) ext_trig_n <= 1'b0;
    settle(6);
    cmp_word(trig_cnt, 32'h2);
    close_out();
  end
endmodule : tb
